// File: core/cialu_top.sv
`timescale 1ns/1ps
`include "cialu_cfg.svh"
// How it works
// - Add-one/subtract-one set N, Z, V, keep C; memory forms hold the lock.
// - Long add/subtract-one 7 cycles; word/byte subtract-one 3; byte add-one 2.
// - Compare subtracts second from first (or low from high half), flags only.
// - Unsigned byte divide of upper half by low byte; quotient low, rest high.
// - Unsigned word divide of long accumulator by operand; remainder to operand.
// - Unsigned word divide by operand: 4 zero, 7 overflow, 22 otherwise.
// - Unsigned byte multiply of halves, flags kept; 3 cycles if multiplier zero, else 7.
// - Unsigned word multiply of halves to long; 3 if upper half zero, else 11.
// - Signed byte divide on accumulator: 3 by zero, 8 or 18 overflow, 18 normal.
// - Signed word divide, dividend not negative: 4, 10 or 29, 30 cycles.
// - Signed word divide, negative dividend: 4, 11 or 30, 31 cycles.
// - Signed divide overflow found before or after the arithmetic step.
// - Accumulator low half is left undefined after signed divide overflow.
// - Signed byte multiply: 3 for zero operand, 12 positive, 13 negative.
// - Signed word multiply: 3 for zero operand, 16 positive, 19 negative.
// - Byte logic sets N and Z, clears V, keeps C; memory forms locked.
// - Half-combining word logic writes accumulator in 2 cycles, clearing V.
// - Inversion takes ones' complement, sets N and Z, clears V.
module cialu_top (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic done, // Last cycle of an operation
  output logic busy, // Operation in progress
  output logic locked_update_access // Memory operand locked
);
  logic [31:0] acc;
  logic [31:0] opnd;
  cialu_pkg::cialu_flags_t flg;
  cialu_pkg::cialu_op_t op_q;
  logic mem_q;
  logic [7:0] cnt;
  logic [7:0] last_cnt;
  logic [7:0] run_len;
  logic [31:0] n_acc;
  logic [31:0] n_opnd;
  cialu_pkg::cialu_flags_t n_flg;
  logic [7:0] n_cnt;

  // Byte-lane merge for partial Wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Shift an operand so its sign bit lands on bit 31
  function automatic logic [31:0] align(input logic [31:0] x, input logic [1:0] w);
    if (w == `CIALU_W8) begin
      return {x[7:0], 24'h000000};
    end else if (w == `CIALU_W16) begin
      return {x[15:0], 16'h0000};
    end
    return x;
  endfunction

  // Flags of x minus y at the given width; aligned, so one 33-bit subtract serves all
  function automatic cialu_pkg::cialu_flags_t sub_flags(input logic [31:0] x,
                                                        input logic [31:0] y,
                                                        input logic [1:0] w);
    logic [31:0] ax;
    logic [31:0] ay;
    logic [32:0] d;
    cialu_pkg::cialu_flags_t f;
    ax = align(x, w);
    ay = align(y, w);
    d = {1'b0, ax} - {1'b0, ay};
    f.n = d[31];
    f.z = (d[31:0] == 32'h00000000);
    f.v = (ax[31] ^ ay[31]) & (ax[31] ^ d[31]);
    f.c = d[32];
    return f;
  endfunction

  // Flags of a logic result: N and Z from value, V cleared, C passed through
  function automatic cialu_pkg::cialu_flags_t log_flags(input logic [31:0] x,
                                                        input logic [1:0] w, input logic c);
    cialu_pkg::cialu_flags_t f;
    f.n = 1'(align(x, w) >> 31);
    f.z = (align(x, w) == 32'h00000000);
    f.v = 1'b0;
    f.c = c;
    return f;
  endfunction

  // Operations that touch a memory operand by read-modify-write
  function automatic logic is_rmw(input cialu_pkg::cialu_op_t op);
    return (op <= cialu_pkg::op_sub1_l) ||
           (op >= cialu_pkg::op_and_b && op <= cialu_pkg::op_not_b);
  endfunction

  // Bus decode
  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i; // Lands on the edge ack is sampled
  wire logic hit_acc = (wb_adr_i == `CIALU_OFS_ACC);
  wire logic hit_opnd = (wb_adr_i == `CIALU_OFS_OPND);
  wire logic hit_flg = (wb_adr_i == `CIALU_OFS_FLAGS);
  wire logic hit_cmd = (wb_adr_i == `CIALU_OFS_CMD);
  wire logic hit_cyc = (wb_adr_i == `CIALU_OFS_CYC);
  wire logic cmd_ok = (wb_dat_i[`CIALU_CMD_OP_MSB:0] <= `CIALU_OP_LAST);
  wire logic start = wr & hit_cmd & wb_sel_i[0] & cmd_ok & ~busy;
  wire cialu_pkg::cialu_op_t cmd_op = cialu_pkg::cialu_op_t'(wb_dat_i[`CIALU_CMD_OP_MSB:0]);
  wire logic cmd_mem = wb_dat_i[`CIALU_CMD_MEM_BIT] & wb_sel_i[1];
  // Operation seen by the datapath: the new command at start, the held one while busy
  wire cialu_pkg::cialu_op_t cur_op = busy ? op_q : cmd_op;
  wire logic [31:0] rd_data = hit_acc ? acc :
                              hit_opnd ? opnd :
                              hit_flg ? {28'h0000000, flg} :
                              hit_cmd ? {19'h00000, op_q, 6'h00, locked_update_access, busy} :
                              hit_cyc ? {24'h000000, last_cnt} : 32'h00000000;

  // Divider inputs; signed forms divide magnitudes and fix signs afterwards
  wire logic sgn_dv = (cur_op == cialu_pkg::op_sdiv_bh) | (cur_op == cialu_pkg::op_sdiv_w);
  wire logic byte_dv = (cur_op == cialu_pkg::op_udiv_bh) | (cur_op == cialu_pkg::op_udiv_b) |
                       (cur_op == cialu_pkg::op_sdiv_bh);
  wire logic [31:0] dvd_raw = (cur_op == cialu_pkg::op_udiv_bh) ? {16'h0000, acc[31:16]} :
                              (cur_op == cialu_pkg::op_udiv_b) ? {16'h0000, acc[15:0]} :
                              (cur_op == cialu_pkg::op_sdiv_bh) ? {{16{acc[31]}}, acc[31:16]} :
                              acc;
  wire logic [15:0] dvs_raw = (cur_op == cialu_pkg::op_udiv_bh) ? {8'h00, acc[7:0]} :
                              (cur_op == cialu_pkg::op_udiv_b) ? {8'h00, opnd[7:0]} :
                              (cur_op == cialu_pkg::op_sdiv_bh) ? {{8{acc[7]}}, acc[7:0]} :
                              opnd[15:0];
  wire logic dvd_neg = sgn_dv & dvd_raw[31];
  wire logic dvs_neg = sgn_dv & dvs_raw[15];
  wire logic [31:0] num = dvd_neg ? -dvd_raw : dvd_raw;
  wire logic [15:0] den = dvs_neg ? -dvs_raw : dvs_raw;
  wire logic den_z = (den == 16'h0000);
  wire logic [31:0] quo = den_z ? 32'h00000000 : num / {16'h0000, den};
  wire logic [31:0] rem32 = den_z ? 32'h00000000 : num % {16'h0000, den};
  wire logic q_neg = dvd_neg ^ dvs_neg;
  // Early overflow: magnitude too wide at all; late: fits unsigned, not signed
  wire logic ov_pre = byte_dv ? (quo[31:8] != 24'h000000) : (quo[31:16] != 16'h0000);
  wire logic ov_post = byte_dv ? (q_neg ? (quo[7:0] > 8'h80) : quo[7]) :
                                 (q_neg ? (quo[15:0] > 16'h8000) : quo[15]);
  wire logic ov_u = den_z | ov_pre;
  wire logic ov_s = den_z | ov_pre | ov_post;
  wire logic [31:0] q_s = q_neg ? -quo : quo;
  wire logic [15:0] r_s = dvd_neg ? -rem32[15:0] : rem32[15:0];

  // Multipliers: unsigned on accumulator halves, signed against the operand
  wire logic [15:0] mua = (cur_op == cialu_pkg::op_umul_bh) ? {8'h00, acc[23:16]} : acc[31:16];
  wire logic [15:0] mub = (cur_op == cialu_pkg::op_umul_bh) ? {8'h00, acc[7:0]} : acc[15:0];
  wire logic [31:0] mu_p = mua * mub;
  wire logic [15:0] msa = (cur_op == cialu_pkg::op_smul_b) ? {{8{acc[7]}}, acc[7:0]} : acc[15:0];
  wire logic [15:0] msb = (cur_op == cialu_pkg::op_smul_b) ? {{8{opnd[7]}}, opnd[7:0]} :
                          opnd[15:0];
  wire logic signed [31:0] ms_p = $signed(msa) * $signed(msb);

  // Result and cycle count of the current operation
  always_comb begin
    n_acc = acc;
    n_opnd = opnd;
    n_flg = flg;
    n_cnt = `CIALU_T_CMP_H;
    case (cur_op)
      cialu_pkg::op_add1_b, cialu_pkg::op_sub1_b: begin
        n_opnd[7:0] = (cur_op == cialu_pkg::op_add1_b) ? opnd[7:0] + 8'h01 : opnd[7:0] - 8'h01;
        n_flg = sub_flags(opnd, (cur_op == cialu_pkg::op_add1_b) ? 32'hffffffff : 32'h1,
                          `CIALU_W8);
        n_flg.c = flg.c;
        n_cnt = (cur_op == cialu_pkg::op_add1_b) ? `CIALU_T_ADD1_B : `CIALU_T_SUB1_BW;
      end
      cialu_pkg::op_add1_w, cialu_pkg::op_sub1_w: begin
        n_opnd[15:0] = (cur_op == cialu_pkg::op_add1_w) ? opnd[15:0] + 16'h0001 :
                       opnd[15:0] - 16'h0001;
        n_flg = sub_flags(opnd, (cur_op == cialu_pkg::op_add1_w) ? 32'hffffffff : 32'h1,
                          `CIALU_W16);
        n_flg.c = flg.c;
        n_cnt = (cur_op == cialu_pkg::op_add1_w) ? `CIALU_T_ADD1_W : `CIALU_T_SUB1_BW;
      end
      cialu_pkg::op_add1_l, cialu_pkg::op_sub1_l: begin
        n_opnd = (cur_op == cialu_pkg::op_add1_l) ? opnd + 32'h1 : opnd - 32'h1;
        n_flg = sub_flags(opnd, (cur_op == cialu_pkg::op_add1_l) ? 32'hffffffff : 32'h1,
                          `CIALU_W32);
        n_flg.c = flg.c;
        n_cnt = `CIALU_T_LONG;
      end
      // Compares leave acc and opnd alone
      cialu_pkg::op_cmp_bh: begin
        n_flg = sub_flags({16'h0000, acc[31:16]}, acc, `CIALU_W8);
      end
      cialu_pkg::op_cmp_wh: begin
        n_flg = sub_flags({16'h0000, acc[31:16]}, acc, `CIALU_W16);
      end
      cialu_pkg::op_cmp_b, cialu_pkg::op_cmp_w: begin
        n_flg = sub_flags(acc, opnd, (cur_op == cialu_pkg::op_cmp_b) ? `CIALU_W8 : `CIALU_W16);
        n_cnt = `CIALU_T_CMP_R;
      end
      cialu_pkg::op_cmp_l: begin
        n_flg = sub_flags(acc, opnd, `CIALU_W32);
        n_cnt = `CIALU_T_CMP_L;
      end
      cialu_pkg::op_udiv_bh, cialu_pkg::op_udiv_b, cialu_pkg::op_udiv_w: begin
        n_flg.v = ov_u;
        n_flg.c = den_z;
        if (!ov_u) begin
          n_acc[7:0] = quo[7:0];
          if (cur_op == cialu_pkg::op_udiv_bh) begin
            n_acc[23:16] = rem32[7:0];
          end else if (cur_op == cialu_pkg::op_udiv_b) begin
            n_opnd[7:0] = rem32[7:0];
          end else begin
            n_acc[15:8] = quo[15:8];
            n_opnd[15:0] = rem32[15:0];
          end
        end
        if (cur_op == cialu_pkg::op_udiv_bh) begin
          n_cnt = ov_u ? `CIALU_T_UDBH_OV : (quo == 32'h0) ? `CIALU_T_ZERO_H :
                  `CIALU_T_UDBH_N;
        end else if (cur_op == cialu_pkg::op_udiv_b) begin
          n_cnt = ov_u ? `CIALU_T_UDB_OV : (quo == 32'h0) ? `CIALU_T_ZERO_R :
                  `CIALU_T_UDB_N;
        end else begin
          n_cnt = ov_u ? `CIALU_T_UDW_OV : (quo == 32'h0) ? `CIALU_T_ZERO_R :
                  `CIALU_T_UDW_N;
        end
      end
      cialu_pkg::op_sdiv_bh: begin
        n_flg.v = ov_s;
        n_flg.c = den_z;
        // On overflow the low half keeps stale data, which callers must treat as undefined
        if (!ov_s) begin
          n_acc[7:0] = q_s[7:0];
          n_acc[23:16] = r_s[7:0];
        end
        n_cnt = den_z ? `CIALU_T_ZERO_H : ov_pre ? `CIALU_T_SDB_PRE : `CIALU_T_SDB_N;
      end
      cialu_pkg::op_sdiv_w: begin
        n_flg.v = ov_s;
        n_flg.c = den_z;
        if (!ov_s) begin
          n_acc[15:0] = q_s[15:0];
          n_opnd[15:0] = r_s;
        end
        // A negative dividend costs one extra cycle on every non-zero path
        n_cnt = den_z ? `CIALU_T_ZERO_R :
                ov_pre ? `CIALU_T_SDW_PRE + {7'h00, dvd_neg} :
                ov_post ? `CIALU_T_SDW_POST + {7'h00, dvd_neg} :
                `CIALU_T_SDW_N + {7'h00, dvd_neg};
      end
      cialu_pkg::op_umul_bh: begin
        n_acc[15:0] = mu_p[15:0];
        n_cnt = (acc[23:16] == 8'h00) ? `CIALU_T_ZERO_H : `CIALU_T_UMB;
      end
      cialu_pkg::op_umul_wh: begin
        n_acc = mu_p;
        n_cnt = (acc[31:16] == 16'h0000) ? `CIALU_T_ZERO_H : `CIALU_T_UMW;
      end
      cialu_pkg::op_smul_b: begin
        n_acc[15:0] = ms_p[15:0];
        n_cnt = (opnd[7:0] == 8'h00) ? `CIALU_T_ZERO_H :
                ms_p[31] ? `CIALU_T_SMB_NEG : `CIALU_T_SMB_POS;
      end
      cialu_pkg::op_smul_w: begin
        n_acc = ms_p;
        n_cnt = (opnd[15:0] == 16'h0000) ? `CIALU_T_ZERO_H :
                ms_p[31] ? `CIALU_T_SMW_NEG : `CIALU_T_SMW_POS;
      end
      cialu_pkg::op_and_b, cialu_pkg::op_or_b, cialu_pkg::op_xor_b: begin
        n_acc[7:0] = (cur_op == cialu_pkg::op_and_b) ? acc[7:0] & opnd[7:0] :
                     (cur_op == cialu_pkg::op_or_b) ? acc[7:0] | opnd[7:0] :
                     acc[7:0] ^ opnd[7:0];
        n_flg = log_flags(n_acc, `CIALU_W8, flg.c);
        n_cnt = `CIALU_T_LOG_B;
      end
      cialu_pkg::op_not_b: begin
        n_opnd[7:0] = ~opnd[7:0];
        n_flg = log_flags(n_opnd, `CIALU_W8, flg.c);
        n_cnt = `CIALU_T_LOG_B;
      end
      cialu_pkg::op_and_wh, cialu_pkg::op_or_wh, cialu_pkg::op_xor_wh: begin
        n_acc[15:0] = (cur_op == cialu_pkg::op_and_wh) ? acc[31:16] & acc[15:0] :
                      (cur_op == cialu_pkg::op_or_wh) ? acc[31:16] | acc[15:0] :
                      acc[31:16] ^ acc[15:0];
        n_flg = log_flags(n_acc, `CIALU_W16, flg.c);
        n_cnt = `CIALU_T_LOG_H;
      end
      cialu_pkg::op_not_w: begin
        n_acc[15:0] = ~acc[15:0];
        n_flg = log_flags(n_acc, `CIALU_W16, flg.c);
        n_cnt = `CIALU_T_LOG_H;
      end
      default: begin
        n_cnt = `CIALU_T_CMP_H;
      end
    endcase
  end

  // Sequencer: count down the data-dependent cycle count, done in the last busy cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 8'h00;
      last_cnt <= 8'h00;
      op_q <= cialu_pkg::op_add1_b;
      mem_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        busy <= 1'b1;
        cnt <= n_cnt;
        last_cnt <= n_cnt;
        done <= (n_cnt == 8'h01);
        op_q <= cmd_op;
        mem_q <= cmd_mem;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
        done <= (cnt == 8'h02);
        busy <= ~done;
      end
    end
  end

  // Lock is held for the whole of a memory-operand update so no other master slips in
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      locked_update_access <= 1'b0;
    end else if (ce) begin
      if (start) begin
        locked_update_access <= cmd_mem & is_rmw(cmd_op);
      end else if (busy && done) begin
        locked_update_access <= 1'b0;
      end
    end
  end

  // Architectural state; software writes are ignored while an operation runs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc <= `CIALU_ACC_RST;
      opnd <= `CIALU_OPND_RST;
      flg <= `CIALU_FLAGS_RST;
    end else if (ce) begin
      if (busy && done) begin
        acc <= n_acc;
        opnd <= n_opnd;
        flg <= n_flg;
      end else if (wr && !busy) begin
        if (hit_acc) begin
          acc <= merge(acc, wb_dat_i, wb_sel_i);
        end
        if (hit_opnd) begin
          opnd <= merge(opnd, wb_dat_i, wb_sel_i);
        end
        if (hit_flg && wb_sel_i[0]) begin
          flg <= wb_dat_i[3:0];
        end
      end
    end
  end

  // Wishbone answer: one wait state, unmapped offsets read zero and are still acked
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 32'h00000000;
    end
  end

  // Busy length counter, read only by the checks below
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_len <= 8'h00;
    end else if (ce) begin
      run_len <= start ? 8'h01 : (busy ? run_len + 8'h01 : 8'h00);
    end
  end

  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  carry_keep_a: assert property (done && busy && op_q <= cialu_pkg::op_sub1_l
    |=> flg.c == $past(flg.c)) else $error("step op changed carry");
  lock_hold_a: assert property (busy && mem_q && is_rmw(op_q)
    |-> locked_update_access) else $error("lock dropped during update");
  long_time_a: assert property (start && cmd_op == cialu_pkg::op_add1_l
    |=> !done [*6] ##1 done) else $error("long add-one not 7 cycles");
  byte_time_a: assert property (start && cmd_op == cialu_pkg::op_sub1_b
    |-> ##3 done) else $error("byte subtract-one not 3 cycles");
  cmp_keep_a: assert property (done && busy && op_q >= cialu_pkg::op_cmp_bh
    && op_q <= cialu_pkg::op_cmp_l |=> $stable(acc) && $stable(opnd))
    else $error("compare changed data");
  udiv_place_a: assert property (done && busy && op_q == cialu_pkg::op_udiv_bh && !ov_u
    |=> acc[7:0] == $past(quo[7:0]) && acc[23:16] == $past(rem32[7:0]))
    else $error("byte quotient misplaced");
  umul_time_a: assert property (start && cmd_op == cialu_pkg::op_umul_bh
    && acc[23:16] != 8'h00 |-> ##7 done) else $error("byte multiply not 7 cycles");
  mul_flags_a: assert property (done && busy && op_q >= cialu_pkg::op_umul_bh
    && op_q <= cialu_pkg::op_umul_wh |=> $stable(flg)) else $error("multiply changed flags");
  logic_v_a: assert property (done && busy && op_q >= cialu_pkg::op_and_b
    |=> !flg.v) else $error("logic op left overflow set");
  done_len_a: assert property (done |-> busy && run_len == last_cnt)
    else $error("done not in final counted cycle");

  sdiv_ovf_c: cover property (start && cmd_op == cialu_pkg::op_sdiv_w && ov_s && !den_z);
  smul_neg_c: cover property (start && cmd_op == cialu_pkg::op_smul_w && ms_p[31]);
  cmp_half_c: cover property (start && cmd_op == cialu_pkg::op_cmp_bh ##1 done);
  lock_upd_c: cover property (start && cmd_mem && cmd_op == cialu_pkg::op_add1_l);
endmodule

// File: core/cialu_cfg.svh
`ifndef CIALU_CFG_SVH
`define CIALU_CFG_SVH
// Register byte offsets
`define CIALU_OFS_ACC 8'h00
`define CIALU_OFS_OPND 8'h04
`define CIALU_OFS_FLAGS 8'h08
`define CIALU_OFS_CMD 8'h0c
`define CIALU_OFS_CYC 8'h10
// Field positions
`define CIALU_CMD_OP_MSB 4
`define CIALU_CMD_MEM_BIT 8
`define CIALU_OP_LAST 5'h1b
// Reset values
`define CIALU_ACC_RST 32'h00000000
`define CIALU_OPND_RST 32'h00000000
`define CIALU_FLAGS_RST 4'h0
// Operand width selectors
`define CIALU_W8 2'h0
`define CIALU_W16 2'h1
`define CIALU_W32 2'h2
// Cycle counts
`define CIALU_T_ADD1_B 8'h02
`define CIALU_T_ADD1_W 8'h03
`define CIALU_T_SUB1_BW 8'h03
`define CIALU_T_LONG 8'h07
`define CIALU_T_CMP_H 8'h01
`define CIALU_T_CMP_R 8'h02
`define CIALU_T_CMP_L 8'h06
`define CIALU_T_LOG_B 8'h03
`define CIALU_T_LOG_H 8'h02
`define CIALU_T_ZERO_H 8'h03
`define CIALU_T_ZERO_R 8'h04
`define CIALU_T_UDBH_OV 8'h07
`define CIALU_T_UDBH_N 8'h0f
`define CIALU_T_UDB_OV 8'h08
`define CIALU_T_UDB_N 8'h10
`define CIALU_T_UDW_OV 8'h07
`define CIALU_T_UDW_N 8'h16
`define CIALU_T_UMB 8'h07
`define CIALU_T_UMW 8'h0b
`define CIALU_T_SDB_PRE 8'h08
`define CIALU_T_SDB_N 8'h12
`define CIALU_T_SDW_PRE 8'h0a
`define CIALU_T_SDW_POST 8'h1d
`define CIALU_T_SDW_N 8'h1e
`define CIALU_T_SMB_POS 8'h0c
`define CIALU_T_SMB_NEG 8'h0d
`define CIALU_T_SMW_POS 8'h10
`define CIALU_T_SMW_NEG 8'h13
`endif

// File: core/cialu_pkg.sv
package cialu_pkg;
  typedef enum logic [4:0] {
    op_add1_b = 5'h00, op_add1_w = 5'h01, op_add1_l = 5'h02,
    op_sub1_b = 5'h03, op_sub1_w = 5'h04, op_sub1_l = 5'h05,
    op_cmp_bh = 5'h06, op_cmp_b = 5'h07, op_cmp_wh = 5'h08,
    op_cmp_w = 5'h09, op_cmp_l = 5'h0a,
    op_udiv_bh = 5'h0b, op_udiv_b = 5'h0c, op_udiv_w = 5'h0d,
    op_umul_bh = 5'h0e, op_umul_wh = 5'h0f,
    op_sdiv_bh = 5'h10, op_sdiv_w = 5'h11, op_smul_b = 5'h12, op_smul_w = 5'h13,
    op_and_b = 5'h14, op_or_b = 5'h15, op_xor_b = 5'h16, op_not_b = 5'h17,
    op_and_wh = 5'h18, op_or_wh = 5'h19, op_xor_wh = 5'h1a, op_not_w = 5'h1b
  } cialu_op_t;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cialu_flags_t;
endpackage

// File: dv/cialu_wbm.sv
`timescale 1ns/1ps
// Classic bus master standing in for the core sequencer
module cialu_wbm (
  input wire logic clk, // Core clock
  input wire logic ack, // Slave acknowledge
  input wire logic [31:0] dat_i, // Read data
  output logic cyc, // Cycle
  output logic stb, // Strobe
  output logic we, // Write enable
  output logic [7:0] adr, // Byte address
  output logic [3:0] sel, // Byte selects
  output logic [31:0] dat // Write data
);
  // Idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end
  // Request held until ack; on release address and data lines flip so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= wd;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_i;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat <= ~wd;
  endtask
endmodule

// File: dv/cialu_top_tb.sv
`timescale 1ns/1ps
module cialu_top_tb;
  typedef struct {logic [4:0] op; logic [31:0] acc; logic [31:0] opd; int n;
    logic [31:0] xa; logic [31:0] xo; logic [3:0] xf;} cialu_row_t;
  logic ref_clk, rst, ce, cyc, stb, we, ack, done, busy, lock;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  int err_total, compares, k;
  // Op, ACC, OPND, cycles, then expected ACC, OPND, FLAGS (FLAGS preset to V and C)
  cialu_row_t rows [17] = '{
    '{5'h00, 32'h0, 32'h7f, 2, 32'h0, 32'h80, 4'hb},
    '{5'h03, 32'h0, 32'h80, 3, 32'h0, 32'h7f, 4'h3},
    '{5'h02, 32'h0, 32'hffffffff, 7, 32'h0, 32'h0, 4'h5},
    '{5'h06, 32'h50005, 32'h0, 1, 32'h50005, 32'h0, 4'h4},
    '{5'h0a, 32'h0, 32'h1, 6, 32'h0, 32'h1, 4'h9},
    '{5'h0b, 32'h640007, 32'h0, 15, 32'h2000e, 32'h0, 4'h0},
    '{5'h0b, 32'h3000002, 32'h0, 7, 32'h3000002, 32'h0, 4'h2},
    '{5'h0c, 32'h1, 32'h5, 4, 32'h0, 32'h1, 4'h0},
    '{5'h0d, 32'h7, 32'h2, 22, 32'h3, 32'h1, 4'h0},
    '{5'h0e, 32'h30004, 32'h0, 7, 32'h3000c, 32'h0, 4'h3},
    '{5'h10, 32'h50000, 32'h0, 3, 32'h50000, 32'h0, 4'h3},
    '{5'h11, 32'h7, 32'h2, 30, 32'h3, 32'h1, 4'h0},
    '{5'h12, 32'hfd, 32'h2, 13, 32'hfffa, 32'h2, 4'h3},
    '{5'h13, 32'h3, 32'h4, 16, 32'hc, 32'h4, 4'h3},
    '{5'h14, 32'hf0, 32'h3c, 3, 32'h30, 32'h3c, 4'h1},
    '{5'h1a, 32'hff0f0f, 32'h0, 2, 32'hff0ff0, 32'h0, 4'h1},
    '{5'h1b, 32'h1234, 32'h0, 2, 32'hedcb, 32'h0, 4'h9}};
  cialu_wbm wbm (.clk(ref_clk), .ack(ack), .dat_i(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat(wdat));
  cialu_top dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .done(done), .busy(busy),
    .locked_update_access(lock));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbm.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wbm.xfer(1'b0, a, 32'h0, rd);
    chk(nm, rd, e);
  endtask
  // Counts edges up to done; lock must follow the memory form for the whole span
  task automatic wait_done(input int n, input logic lk);
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      chk("lock", {31'h0, lock}, {31'h0, lk});
      chk("busy", {31'h0, busy}, 32'h1);
    end while (done !== 1'b1 && k < 40);
    chk("cycles", k, n);
  endtask
  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    #50000;
    err_total++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("acc rst", 8'h00, 32'h0);
    rdc("flags rst", 8'h08, 32'h0);
    wr(8'h20, 32'hffffffff);
    rdc("unmapped", 8'h20, 32'h0);
    foreach (rows[i]) begin
      wr(8'h08, 32'h3);
      wr(8'h00, rows[i].acc);
      wr(8'h04, rows[i].opd);
      wr(8'h0c, {27'h0, rows[i].op});
      wait_done(rows[i].n, 1'b0);
      rdc("acc", 8'h00, rows[i].xa);
      rdc("opnd", 8'h04, rows[i].xo);
      rdc("flags", 8'h08, {28'h0, rows[i].xf});
      rdc("cyc", 8'h10, rows[i].n);
      $display("row %0d ended", i);
    end
    // Writes during a long divide are dropped; each write costs three edges
    wr(8'h00, 32'h7);
    wr(8'h04, 32'h2);
    wr(8'h0c, 32'h0d);
    wr(8'h00, 32'hffffffff);
    wr(8'h0c, 32'h00);
    wait_done(16, 1'b0);
    rdc("acc busy", 8'h00, 32'h3);
    rdc("cyc busy", 8'h10, 32'h16);
    wr(8'h0c, 32'h114);
    wait_done(3, 1'b1);
    // Negative dividend: one cycle more, remainder keeps the dividend sign
    wr(8'h00, 32'hfffffff9);
    wr(8'h04, 32'h2);
    wr(8'h0c, 32'h11);
    wait_done(31, 1'b0);
    rdc("rem sign", 8'h04, 32'hffff);
    $display("hand tests ended");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rdc("acc rerst", 8'h00, 32'h0);
    rdc("flags rerst", 8'h08, 32'h0);
    tally_and_finish();
  end
endmodule
